// [include/acc_pkg.sv]
// shared constants and carriers for the analog compare control block
package acc_pkg;

	// bus geometry
	localparam int ADDR_W = 12; // byte address width on the register bus
	localparam int DATA_W = 32; // register bus data width

	// register indexes; byte address is four times the index
	localparam logic [7:0] IDX_CMP_CTRL_STATUS = 8'h50; // comparator_control_status
	localparam logic [7:0] IDX_CONV_CTRL_B = 8'h7b; // converter_control_b
	localparam logic [7:0] IDX_PIN_INPUT_DIS = 8'h7f; // comparator_pin_input_disable

	// comparator_control_status field positions
	localparam int CCS_DISABLE = 7; // comparator_disable
	localparam int CCS_BANDGAP = 6; // bandgap_select
	localparam int CCS_RESULT = 5; // compare_result, read only
	localparam int CCS_FLAG = 4; // compare_irq_flag
	localparam int CCS_IRQ_EN = 3; // compare_irq_enable
	localparam int CCS_CAPTURE = 2; // capture_route
	localparam int CCS_MODE_HI = 1; // edge_mode_hi
	localparam int CCS_MODE_LO = 0; // edge_mode_lo

	// converter_control_b field positions
	localparam int CCB_MUX_EN = 6; // neg_mux_enable
	localparam int CCB_UPPER = 3; // upper_bank_select
	localparam int CCB_TRIG_HI = 2; // converter trigger select, top bit
	localparam int CCB_TRIG_LO = 0; // converter trigger select, low bit

	// comparator_pin_input_disable field positions
	localparam int PID_NEG_OFF = 1; // neg_pin_input_off
	localparam int PID_POS_OFF = 0; // pos_pin_input_off

	// reset values of the writable fields
	localparam logic [7:0] RST_CMP_CTRL_STATUS = 8'h00;
	localparam logic [7:0] RST_CONV_CTRL_B = 8'h00;
	localparam logic [7:0] RST_PIN_INPUT_DIS = 8'h00;

	// edge mode encodings
	localparam logic [1:0] MODE_TOGGLE = 2'h0; // any change of the output
	localparam logic [1:0] MODE_RESERVED = 2'h1; // no event at all
	localparam logic [1:0] MODE_FALL = 2'h2; // falling output edge
	localparam logic [1:0] MODE_RISE = 2'h3; // rising output edge

	// synchroniser depth for pin and comparator inputs
	localparam int SYNC_STAGES = 2;

	// apb request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} acc_apb_req_t;

	// apb answer to the master
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [DATA_W-1:0] prdata;
	} acc_apb_rsp_t;

	// byte address of a register index
	function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
		reg_addr = {2'h0, idx, 2'h0};
	endfunction : reg_addr

endpackage : acc_pkg

// [rtl/acc_sync.sv]
`timescale 1ns/1ps
// two-stage synchroniser; the second stage can hold its value
module acc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] async_in,
	input wire logic [WIDTH-1:0] hold,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1; // first stage, read only by the second

	// first stage samples the foreign level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1 <= '0;
		end else begin
			stage1 <= async_in;
		end
	end

	// second stage follows unless held, per bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_out <= '0;
		end else begin
			sync_out <= (stage1 & ~hold) | (sync_out & hold);
		end
	end

endmodule : acc_sync

// [rtl/acc_top.sv]
`timescale 1ns/1ps
// Function
// - result high when positive exceeds negative input
// - result synchronised, one to two cycles late
// - mux on, converter off and not power gated: pin bank*8+select
// - mux off or converter on: negative pin
// - bandgap select replaces positive pin
// - disable bit powers comparator off anytime
// - matching synchronised event sets irq flag
// - mode 00 toggle, 01 none, 10 fall, 11 rise
// - irq while flag, enable and global enable
// - flag clears when handler is vectored
// - writing one clears flag, zero keeps
// - capture route feeds timer capture front end
// - input disable kills buffer, port reads zero
// - reserved bits zero, writable bits reset zero
// - converter enable gates mux availability
module acc_top (
	input wire logic pclk,
	input wire logic presetn,
	input acc_pkg::acc_apb_req_t apb_req,
	output acc_pkg::acc_apb_rsp_t apb_rsp,
	input wire logic cmp_raw,
	input wire logic positive_pin_level,
	input wire logic negative_pin_level,
	input wire logic converter_enable,
	input wire logic converter_power_gate,
	input wire logic [2:0] pin_select_low,
	input wire logic global_irq_enable,
	input wire logic irq_vector_ack,
	output logic compare_irq,
	output logic comparator_power_off,
	output logic bandgap_route,
	output logic neg_mux_route,
	output logic [3:0] neg_pin_index,
	output logic capture_trigger,
	output logic [2:0] converter_trigger_select,
	output logic pos_pin_buffer_off,
	output logic neg_pin_buffer_off,
	output logic pos_pin_port_bit,
	output logic neg_pin_port_bit
);

	// software-visible control fields
	// one flop each except edge_mode and trigger_select; compare_irq_flag has its own process, the rest their register's
	logic comparator_disable; // powers the comparator off
	logic bandgap_select; // positive input from the bandgap
	logic compare_irq_flag; // sticky event flag
	logic compare_irq_enable; // lets the flag reach the request
	logic capture_route; // result to timer capture
	logic [1:0] edge_mode; // event selection
	logic neg_mux_enable; // negative input from the shared mux
	logic upper_bank_select; // selects pins 8 to 15
	logic [2:0] trigger_select; // converter trigger source, stored only
	logic neg_pin_input_off; // negative pin buffer off
	logic pos_pin_input_off; // positive pin buffer off

	// synchronised comparator result and its history
	// result and history reset to the same level
	logic compare_result; // synchronised, held while disabled
	logic prev_result; // result one cycle earlier
	logic [1:0] pin_sync; // synchronised pin levels

	// edge pulses
	// combinational, read only by the flag logic
	logic rise_pulse; // result went high
	logic fall_pulse; // result went low
	logic toggle_pulse; // result changed
	logic event_hit; // event matches the mode

	// bus decode
	// all decode is combinational on the request
	logic setup_phase; // first cycle of a transfer
	logic write_access; // access phase of a write
	logic hit_ccs; // address matches control/status
	logic hit_ccb; // address matches converter control b
	logic hit_pid; // address matches input disable
	logic flag_clear; // write one to the flag
	logic next_flag; // next value of the flag

	// read data assembled from the current state
	// views are rebuilt every cycle from the live flops
	logic [7:0] ccs_view; // control/status as read
	logic [7:0] ccb_view; // converter control b as read
	logic [7:0] pid_view; // input disable as read
	logic [acc_pkg::DATA_W-1:0] next_prdata; // data for the access phase
	logic next_pslverr; // unmapped address answer

	// place a register byte on the bus, upper bits zero
	function automatic logic [acc_pkg::DATA_W-1:0] widen_byte(input logic [7:0] view);
		widen_byte = {{(acc_pkg::DATA_W-8){1'b0}}, view};
	endfunction : widen_byte

	// comparator result: the analog stage resolves pos > neg, this stage syncs it
	// hold freezes the second stage while powered off, so no edge is seen
	// the first stage still follows the dead output; only the second is held
	acc_sync #(
		.WIDTH(1)
	) u_cmp_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(cmp_raw),
		.hold(comparator_disable),
		.sync_out(compare_result)
	);

	// pin levels for the port input bits
	// both pins are foreign levels, so they pass two flops first
	acc_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({negative_pin_level, positive_pin_level}),
		.hold(2'h0),
		.sync_out(pin_sync)
	);

	// address decode against the register indexes
	// a write lands at the access edge; pready stays high after reset
	always_comb begin
		setup_phase = apb_req.psel && !apb_req.penable;
		write_access = apb_req.psel && apb_req.penable && apb_req.pwrite;
		hit_ccs = apb_req.paddr == acc_pkg::reg_addr(acc_pkg::IDX_CMP_CTRL_STATUS);
		hit_ccb = apb_req.paddr == acc_pkg::reg_addr(acc_pkg::IDX_CONV_CTRL_B);
		hit_pid = apb_req.paddr == acc_pkg::reg_addr(acc_pkg::IDX_PIN_INPUT_DIS);
	end

	// read views; reserved bits are zero
	// the result position is read only; writes to it are dropped
	always_comb begin
		ccs_view = 8'h00;
		ccs_view[acc_pkg::CCS_DISABLE] = comparator_disable;
		ccs_view[acc_pkg::CCS_BANDGAP] = bandgap_select;
		ccs_view[acc_pkg::CCS_RESULT] = compare_result;
		ccs_view[acc_pkg::CCS_FLAG] = compare_irq_flag;
		ccs_view[acc_pkg::CCS_IRQ_EN] = compare_irq_enable;
		ccs_view[acc_pkg::CCS_CAPTURE] = capture_route;
		ccs_view[acc_pkg::CCS_MODE_HI] = edge_mode[1];
		ccs_view[acc_pkg::CCS_MODE_LO] = edge_mode[0];
		ccb_view = 8'h00;
		ccb_view[acc_pkg::CCB_MUX_EN] = neg_mux_enable;
		ccb_view[acc_pkg::CCB_UPPER] = upper_bank_select;
		ccb_view[acc_pkg::CCB_TRIG_HI:acc_pkg::CCB_TRIG_LO] = trigger_select;
		pid_view = 8'h00;
		pid_view[acc_pkg::PID_NEG_OFF] = neg_pin_input_off;
		pid_view[acc_pkg::PID_POS_OFF] = pos_pin_input_off;
	end

	// read mux, evaluated in the setup cycle
	// data taken at setup stands unchanged through the access phase
	always_comb begin
		next_prdata = '0; // unmapped reads return zero
		next_pslverr = 1'b0;
		if (hit_ccs) begin
			// control/status with the live result bit
			next_prdata = widen_byte(ccs_view);
		end else if (hit_ccb) begin
			// converter control b, trigger bits included
			next_prdata = widen_byte(ccb_view);
		end else if (hit_pid) begin
			// input disable, two live bits
			next_prdata = widen_byte(pid_view);
		end else begin
			// unmapped: error answer, zero data
			next_pslverr = 1'b1;
		end
	end

	// bus answer: zero wait states, data and error latched at setup
	// no wait states, so pready simply rises at the first edge after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_rsp <= '0;
		end else begin
			apb_rsp.pready <= 1'b1; // every access phase ends at once
			if (setup_phase) begin
				// write transfers answer with zero data
				apb_rsp.prdata <= apb_req.pwrite ? '0 : next_prdata;
				apb_rsp.pslverr <= next_pslverr;
			end
		end
	end

	// control/status writable fields
	// the flag and the result bit are handled elsewhere
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// all writable fields start at zero
			comparator_disable <= acc_pkg::RST_CMP_CTRL_STATUS[acc_pkg::CCS_DISABLE];
			bandgap_select <= acc_pkg::RST_CMP_CTRL_STATUS[acc_pkg::CCS_BANDGAP];
			compare_irq_enable <= acc_pkg::RST_CMP_CTRL_STATUS[acc_pkg::CCS_IRQ_EN];
			capture_route <= acc_pkg::RST_CMP_CTRL_STATUS[acc_pkg::CCS_CAPTURE];
			edge_mode <= acc_pkg::RST_CMP_CTRL_STATUS[acc_pkg::CCS_MODE_HI:acc_pkg::CCS_MODE_LO];
		end else if (write_access && hit_ccs) begin
			// disable may be written at any time
			// software drops the irq enable first, or a stray event may follow
			comparator_disable <= apb_req.pwdata[acc_pkg::CCS_DISABLE];
			bandgap_select <= apb_req.pwdata[acc_pkg::CCS_BANDGAP];
			compare_irq_enable <= apb_req.pwdata[acc_pkg::CCS_IRQ_EN];
			capture_route <= apb_req.pwdata[acc_pkg::CCS_CAPTURE];
			edge_mode <= apb_req.pwdata[acc_pkg::CCS_MODE_HI:acc_pkg::CCS_MODE_LO];
		end
	end

	// converter control b fields
	// trigger bits belong to the converter; they are only stored here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// mux off and trigger bits clear after reset
			neg_mux_enable <= acc_pkg::RST_CONV_CTRL_B[acc_pkg::CCB_MUX_EN];
			upper_bank_select <= acc_pkg::RST_CONV_CTRL_B[acc_pkg::CCB_UPPER];
			trigger_select <= acc_pkg::RST_CONV_CTRL_B[acc_pkg::CCB_TRIG_HI:acc_pkg::CCB_TRIG_LO];
		end else if (write_access && hit_ccb) begin
			neg_mux_enable <= apb_req.pwdata[acc_pkg::CCB_MUX_EN];
			upper_bank_select <= apb_req.pwdata[acc_pkg::CCB_UPPER];
			trigger_select <= apb_req.pwdata[acc_pkg::CCB_TRIG_HI:acc_pkg::CCB_TRIG_LO];
		end
	end

	// pin input disable fields
	// a set bit turns the digital buffer off and zeroes the port bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// both buffers on after reset
			neg_pin_input_off <= acc_pkg::RST_PIN_INPUT_DIS[acc_pkg::PID_NEG_OFF];
			pos_pin_input_off <= acc_pkg::RST_PIN_INPUT_DIS[acc_pkg::PID_POS_OFF];
		end else if (write_access && hit_pid) begin
			neg_pin_input_off <= apb_req.pwdata[acc_pkg::PID_NEG_OFF];
			pos_pin_input_off <= apb_req.pwdata[acc_pkg::PID_POS_OFF];
		end
	end

	// previous result for edge detection
	// resets to the same level as the synchroniser, so no false edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_result <= 1'b0;
		end else begin
			prev_result <= compare_result;
		end
	end

	// edge pulses and mode match
	// each pulse lasts one cycle; the reserved code raises nothing
	// a mode change alone fakes no edge, pulses need a result change; software drops the enable first
	always_comb begin
		rise_pulse = compare_result && !prev_result;
		fall_pulse = !compare_result && prev_result;
		toggle_pulse = rise_pulse || fall_pulse;
		unique case (edge_mode)
			acc_pkg::MODE_TOGGLE: event_hit = toggle_pulse;
			acc_pkg::MODE_RESERVED: event_hit = 1'b0;
			acc_pkg::MODE_FALL: event_hit = fall_pulse;
			acc_pkg::MODE_RISE: event_hit = rise_pulse;
		endcase
	end

	// flag next value; a new event wins over any clear
	// vectoring and a written one share the clear path
	always_comb begin
		flag_clear = write_access && hit_ccs && apb_req.pwdata[acc_pkg::CCS_FLAG];
		next_flag = compare_irq_flag;
		if (flag_clear || irq_vector_ack) begin
			next_flag = 1'b0;
		end
		if (event_hit) begin
			next_flag = 1'b1;
		end
	end

	// sticky interrupt flag
	// stays set until vectored or cleared by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_irq_flag <= 1'b0;
		end else begin
			compare_irq_flag <= next_flag;
		end
	end

	// interrupt request to the processor
	// built from next_flag, so request and flag rise together
	// the global enable is a same-clock level from the processor
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_irq <= 1'b0;
		end else begin
			compare_irq <= next_flag && compare_irq_enable && global_irq_enable;
		end
	end

	// analog input selection
	// the comparator core sees these registered selects
	// the pin index is passed on even when the mux is not routed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bandgap_route <= 1'b0;
			neg_mux_route <= 1'b0;
			neg_pin_index <= 4'h0;
			comparator_power_off <= 1'b0;
		end else begin
			bandgap_route <= bandgap_select;
			// mux only when the converter is off and its power gate open
			neg_mux_route <= neg_mux_enable && !converter_enable
				&& !converter_power_gate;
			neg_pin_index <= {upper_bank_select, pin_select_low};
			comparator_power_off <= comparator_disable;
		end
	end

	// timer capture routing
	// the capture interrupt itself is enabled inside the timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_trigger <= 1'b0;
		end else begin
			// no connection unless routed; timer filters the edge itself
			capture_trigger <= capture_route && compare_result;
		end
	end

	// converter trigger source passes through
	// a registered copy keeps the output straight from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			converter_trigger_select <= 3'h0;
		end else begin
			converter_trigger_select <= trigger_select;
		end
	end

	// digital input buffers and port input bits
	// port bits lag the pins by three edges: two sync, one output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_pin_buffer_off <= 1'b0;
			neg_pin_buffer_off <= 1'b0;
			pos_pin_port_bit <= 1'b0;
			neg_pin_port_bit <= 1'b0;
		end else begin
			pos_pin_buffer_off <= pos_pin_input_off;
			neg_pin_buffer_off <= neg_pin_input_off;
			// a disabled buffer reads as zero
			pos_pin_port_bit <= pin_sync[0] && !pos_pin_input_off;
			neg_pin_port_bit <= pin_sync[1] && !neg_pin_input_off;
		end
	end

endmodule : acc_top

// [bench/acc_top_sva.sv]
`timescale 1ns/1ps
// port-level watch on routing, masking and register reads
module acc_top_sva (
	input wire logic pclk,
	input wire logic presetn,
	input acc_pkg::acc_apb_req_t apb_req,
	input acc_pkg::acc_apb_rsp_t apb_rsp,
	input wire logic converter_enable,
	input wire logic converter_power_gate,
	input wire logic [2:0] pin_select_low,
	input wire logic global_irq_enable,
	input wire logic compare_irq,
	input wire logic comparator_power_off,
	input wire logic neg_mux_route,
	input wire logic [3:0] neg_pin_index,
	input wire logic pos_pin_buffer_off,
	input wire logic neg_pin_buffer_off,
	input wire logic pos_pin_port_bit,
	input wire logic neg_pin_port_bit
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic ccs_wr; // access-phase write to control/status
	logic pid_setup; // setup cycle on the input-disable register
	assign ccs_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == 12'h140;
	assign pid_setup = apb_req.psel && !apb_req.penable && apb_req.paddr == 12'h1fc;
	irq_mask_a: assert property (!global_irq_enable |=> !compare_irq)
		else $error("irq raised while global enable low");
	power_off_a: assert property (ccs_wr |-> ##2
		comparator_power_off == $past(apb_req.pwdata[7], 2))
		else $error("power-off output differs from written bit");
	mux_conv_a: assert property (converter_enable [*2] |-> !neg_mux_route)
		else $error("mux route while converter on");
	mux_gate_a: assert property (converter_power_gate [*2] |-> !neg_mux_route)
		else $error("mux route while converter power gated");
	pin_index_a: assert property ($past(presetn) && $stable(pin_select_low) |->
		neg_pin_index[2:0] == pin_select_low) else $error("pin index low bits wrong");
	pos_off_a: assert property (pos_pin_buffer_off && $past(pos_pin_buffer_off) |-> !pos_pin_port_bit)
		else $error("positive port bit high with buffer off");
	neg_off_a: assert property (neg_pin_buffer_off && $past(neg_pin_buffer_off) |-> !neg_pin_port_bit)
		else $error("negative port bit high with buffer off");
	reserved_zero_a: assert property (pid_setup |=> apb_rsp.prdata[31:2] == 30'h0)
		else $error("reserved bits read nonzero");
endmodule : acc_top_sva

bind acc_top acc_top_sva u_acc_top_sva (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .converter_enable(converter_enable),
	.converter_power_gate(converter_power_gate), .pin_select_low(pin_select_low),
	.global_irq_enable(global_irq_enable), .compare_irq(compare_irq),
	.comparator_power_off(comparator_power_off), .neg_mux_route(neg_mux_route),
	.neg_pin_index(neg_pin_index), .pos_pin_buffer_off(pos_pin_buffer_off),
	.neg_pin_buffer_off(neg_pin_buffer_off), .pos_pin_port_bit(pos_pin_port_bit),
	.neg_pin_port_bit(neg_pin_port_bit));

// [bench/acc_analog_model.sv]
`timescale 1ns/1ps
// far side: comparator core and analog pins
module acc_analog_model (
	input wire logic pclk,
	input wire logic bandgap_route,
	input wire logic neg_mux_route,
	input wire logic [3:0] neg_pin_index,
	input wire logic comparator_power_off,
	input wire logic [7:0] pos_mv,
	input wire logic [7:0] neg_mv,
	input wire logic [7:0] bg_mv,
	input wire logic [15:0][7:0] conv_mv,
	output logic cmp_raw,
	output logic positive_pin_level,
	output logic negative_pin_level
);
	logic spin = 1'b0; // unsettled output while unpowered
	// free toggling stands for a dead comparator
	always @(posedge pclk) spin <= ~spin;
	// strict greater-than on the selected inputs
	always_comb begin
		if (comparator_power_off) begin
			cmp_raw = spin;
		end else begin
			cmp_raw = (bandgap_route ? bg_mv : pos_mv) >
				(neg_mux_route ? conv_mv[neg_pin_index] : neg_mv);
		end
	end
	// digital pin level from the top of the analog level
	assign positive_pin_level = pos_mv[7];
	assign negative_pin_level = neg_mv[7];
endmodule : acc_analog_model

// [bench/acc_top_tb.sv]
`timescale 1ns/1ps
// self-checking bench for the compare control block
module acc_top_tb;
	localparam logic [7:0] CCS = acc_pkg::IDX_CMP_CTRL_STATUS;
	localparam logic [7:0] CCB = acc_pkg::IDX_CONV_CTRL_B;
	localparam logic [7:0] PID = acc_pkg::IDX_PIN_INPUT_DIS;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	acc_pkg::acc_apb_req_t req = '0;
	acc_pkg::acc_apb_rsp_t rsp;
	logic cmp_raw, pos_lvl, neg_lvl, irq, pwr_off, bg_rt, mux_rt, cap;
	logic pbuf, nbuf, pport, nport, rerr, e;
	logic conv_en = 1'b0;
	logic pwr_gate = 1'b0;
	logic gie = 1'b0;
	logic ack = 1'b0;
	logic cap_ie = 1'b0; // timer capture irq enable, software side
	logic [2:0] sel_low = 3'h0;
	logic [2:0] trig;
	logic [3:0] nidx;
	logic [7:0] pos_mv = 8'hf0;
	logic [7:0] neg_mv = 8'hf0;
	logic [7:0] bg_mv = 8'hc0;
	logic [15:0][7:0] conv_mv;
	logic [31:0] rdat;
	int n_errors = 0;
	int tests_run = 0;
	// 50 MHz clock
	always #10 pclk = ~pclk;
	acc_top u_acc_top (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.cmp_raw(cmp_raw), .positive_pin_level(pos_lvl), .negative_pin_level(neg_lvl),
		.converter_enable(conv_en), .converter_power_gate(pwr_gate), .pin_select_low(sel_low),
		.global_irq_enable(gie), .irq_vector_ack(ack), .compare_irq(irq),
		.comparator_power_off(pwr_off), .bandgap_route(bg_rt), .neg_mux_route(mux_rt),
		.neg_pin_index(nidx), .capture_trigger(cap), .converter_trigger_select(trig),
		.pos_pin_buffer_off(pbuf), .neg_pin_buffer_off(nbuf), .pos_pin_port_bit(pport),
		.neg_pin_port_bit(nport));
	acc_analog_model u_acc_analog_model (.pclk(pclk), .bandgap_route(bg_rt),
		.neg_mux_route(mux_rt), .neg_pin_index(nidx), .comparator_power_off(pwr_off),
		.pos_mv(pos_mv), .neg_mv(neg_mv), .bg_mv(bg_mv), .conv_mv(conv_mv),
		.cmp_raw(cmp_raw), .positive_pin_level(pos_lvl), .negative_pin_level(neg_lvl));
	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask : idle
	// one apb transfer, held until pready
	task automatic xfer(input logic [7:0] idx, input logic w, input logic [7:0] d);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= {2'h0, idx, 2'h0};
		req.pwdata <= {24'h0, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		@(posedge pclk);
		while (rsp.pready !== 1'b1) @(posedge pclk);
		rdat = rsp.prdata;
		rerr = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// full register read with no error
	task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
		xfer(idx, 1'b0, 8'h0);
		chk(rdat, exp);
		chk(32'(rerr), 32'h0);
	endtask : rd
	// result bit only
	task automatic res_chk(input logic b);
		xfer(CCS, 1'b0, 8'h0);
		chk(rdat & 32'h20, {26'h0, b, 5'h0});
	endtask : res_chk
	task automatic tally_and_finish;
		if (n_errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// hang guard, far beyond the expected run
	initial begin
		#400000;
		n_errors++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		for (int i = 0; i < 16; i++) conv_mv[i] = 8'(i * 16);
		idle(12);
		presetn <= 1'b1;
		idle(1);
		rd(CCS, 32'h0);
		rd(CCB, 32'h0);
		rd(PID, 32'h0);
		xfer(PID, 1'b1, 8'hff);
		rd(PID, 32'h3);
		chk({28'h0, pbuf, nbuf, pport, nport}, 32'hc);
		xfer(PID, 1'b1, 8'h00);
		idle(4);
		chk({28'h0, pbuf, nbuf, pport, nport}, 32'h3);
		xfer(8'h51, 1'b0, 8'h0);
		chk({rdat[30:0], rerr}, 32'h1);
		pos_mv <= 8'h78;
		neg_mv <= 8'h20;
		for (int i = 0; i < 16; i++) begin
			sel_low <= 3'(i);
			xfer(CCB, 1'b1, {4'h4, 1'(i >> 3), 3'h7});
			idle(4);
			chk({27'h0, mux_rt, nidx}, {27'h1, 4'(i)});
			res_chk(8'h78 > conv_mv[i]);
		end
		rd(CCB, 32'h4f);
		chk(32'(trig), 32'h7);
		conv_en <= 1'b1;
		idle(3);
		chk(32'(mux_rt), 32'h0);
		res_chk(1'b1);
		conv_en <= 1'b0;
		pwr_gate <= 1'b1;
		idle(3);
		chk(32'(mux_rt), 32'h0);
		pwr_gate <= 1'b0;
		xfer(CCB, 1'b1, 8'h00);
		idle(3);
		chk(32'(mux_rt), 32'h0);
		pos_mv <= 8'h10;
		neg_mv <= 8'h80;
		xfer(CCS, 1'b1, 8'h40);
		// let the bandgap settle before trusting the result
		idle(8);
		chk(32'(bg_rt), 32'h1);
		res_chk(1'b1);
		xfer(CCS, 1'b1, 8'h00);
		idle(4);
		res_chk(1'b0);
		gie <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			xfer(CCS, 1'b1, 8'h10 | 8'(m));
			xfer(CCS, 1'b1, 8'h18 | 8'(m));
			pos_mv <= 8'hf0;
			idle(6);
			e = (m == 0 || m == 3);
			chk(32'(irq), 32'(e));
			rd(CCS, {26'h0, 1'b1, e, 2'h2, 2'(m)});
			xfer(CCS, 1'b1, 8'h18 | 8'(m));
			pos_mv <= 8'h10;
			idle(6);
			e = (m == 0 || m == 2);
			chk(32'(irq), 32'(e));
			rd(CCS, {26'h0, 1'b0, e, 2'h2, 2'(m)});
		end
		gie <= 1'b0;
		pos_mv <= 8'hf0;
		idle(6);
		chk(32'(irq), 32'h0);
		xfer(CCS, 1'b1, 8'h0b);
		rd(CCS, 32'h3b);
		gie <= 1'b1;
		idle(2);
		chk(32'(irq), 32'h1);
		ack <= 1'b1;
		idle(1);
		ack <= 1'b0;
		idle(2);
		chk(32'(irq), 32'h0);
		rd(CCS, 32'h2b);
		xfer(CCS, 1'b1, 8'h13);
		xfer(CCS, 1'b1, 8'h93);
		idle(2);
		chk(32'(pwr_off), 32'h1);
		idle(10);
		rd(CCS, 32'ha3);
		idle(7);
		rd(CCS, 32'ha3);
		xfer(CCS, 1'b1, 8'h17);
		cap_ie <= 1'b1;
		idle(4);
		chk(32'(cap), 32'h1);
		chk(32'(cap & cap_ie), 32'h1);
		pos_mv <= 8'h10;
		idle(6);
		chk(32'(cap), 32'h0);
		pos_mv <= 8'hf0;
		idle(6);
		xfer(CCS, 1'b1, 8'h03);
		idle(3);
		chk(32'(cap), 32'h0);
		tally_and_finish();
	end
endmodule : acc_top_tb
